// [rtl/hth_pkg.sv]
// Constants and types shared by the compare timer and its helpers
package hth_pkg;
    // Register byte offsets
    localparam logic [7:0] HTH_OFS_CTRL   = 8'h00;
    localparam logic [7:0] HTH_OFS_PERIOD = 8'h04;
    localparam logic [7:0] HTH_OFS_DUTY   = 8'h08;
    localparam logic [7:0] HTH_OFS_GATE   = 8'h0C;
    localparam logic [7:0] HTH_OFS_CMPN   = 8'h10;
    localparam logic [7:0] HTH_OFS_STATUS = 8'h14;
    // Widths
    localparam int unsigned HTH_ADDR_W = 8;
    localparam int unsigned HTH_DATA_W = 32;
    localparam int unsigned HTH_CNT_W  = 8;
    localparam int unsigned HTH_SEL_W  = 3;
    // Count clocks from duty write to active compare
    localparam int unsigned HTH_DUTY_LOAD_TICKS = 3;
    // Gate register field positions
    localparam int unsigned HTH_GATE_BUF_BIT = 0;
    localparam int unsigned HTH_GATE_ACT_BIT = 1;
    // Status register field positions
    localparam int unsigned HTH_ST_CNT_LSB  = 0;
    localparam int unsigned HTH_ST_OUT_BIT  = 8;
    localparam int unsigned HTH_ST_LOAD_BIT = 9;
    localparam int unsigned HTH_ST_CCNT_LSB = 16;
    // AXI responses
    localparam logic [1:0] HTH_RESP_OKAY   = 2'h0;
    localparam logic [1:0] HTH_RESP_SLVERR = 2'h2;
    // Control register layout, bit 0 at the bottom
    typedef struct packed {
        logic [2:0] cmp_clk_sel;
        logic       rsvd;
        logic       cmp_run;
        logic       out_level;
        logic [2:0] clk_sel;
        logic       carrier;
        logic       run;
    } hth_ctrl_t;
    localparam int unsigned HTH_CTRL_W = 11;
    localparam hth_ctrl_t HTH_CTRL_RST = 11'h000;
    localparam logic [7:0] HTH_PERIOD_RST = 8'hFF;
    localparam logic [7:0] HTH_DUTY_RST   = 8'h00;
    localparam logic [7:0] HTH_CMPN_RST   = 8'hFF;
endpackage

// [rtl/hth_prescale.sv]
// Count clock prescaler producing one tick every 2**sel clocks
`timescale 1ns/10ps
`default_nettype none
module hth_prescale #(
    parameter int unsigned SEL_W = 3,
    parameter int unsigned DIV_W = 8
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Control
    input  wire logic             en,
    input  wire logic [SEL_W-1:0] sel,
    // Tick
    output logic                  tick
);
    logic [DIV_W-1:0] div_ff;
    logic [DIV_W-1:0] nxt_div;
    logic [DIV_W-1:0] mask;

    always_comb begin
        mask    = ~({DIV_W{1'b1}} << sel);
        tick    = en && ((div_ff & mask) == mask);
        nxt_div = en ? div_ff + 1'b1 : '0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_ff <= '0;
        end else begin
            div_ff <= nxt_div;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    tick_full_rate_a: assert property (en && sel == '0 && $past(en) |-> tick)
        else $error("Prescaler missed tick at full rate");
    tick_idle_a: assert property (!en |-> !tick)
        else $error("Prescaler ticked while disabled");
endmodule // hth_prescale
`default_nettype wire

// [rtl/hth_shadow_load.sv]
// Duty compare buffer moved to the active compare after a tick delay
`timescale 1ns/10ps
`default_nettype none
module hth_shadow_load #(
    parameter int unsigned W     = 8,
    parameter int unsigned DELAY = 3
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Control
    input  wire logic         clr,
    input  wire logic         tick,
    input  wire logic         wr,
    input  wire logic [W-1:0] wr_data,
    // Active value
    output logic [W-1:0]      act,
    output logic              loaded
);
    localparam int unsigned CW = $clog2(DELAY + 1);
    localparam logic [CW-1:0] LAST = CW'(DELAY - 1);

    logic [W-1:0]  pend_ff, nxt_pend, act_ff, nxt_act;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic          busy_ff, nxt_busy, loaded_ff, nxt_loaded;

    always_comb begin
        nxt_pend   = pend_ff;
        nxt_act    = act_ff;
        nxt_cnt    = cnt_ff;
        nxt_busy   = busy_ff;
        nxt_loaded = clr ? 1'b0 : loaded_ff;
        if (wr) begin
            nxt_pend = wr_data;
            nxt_busy = 1'b1;
            nxt_cnt  = '0;
        end else if (busy_ff && tick) begin
            if (cnt_ff == LAST) begin
                nxt_act    = pend_ff;
                nxt_busy   = 1'b0;
                nxt_loaded = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_ff   <= '0;
            act_ff    <= '0;
            cnt_ff    <= '0;
            busy_ff   <= 1'b0;
            loaded_ff <= 1'b0;
        end else begin
            pend_ff   <= nxt_pend;
            act_ff    <= nxt_act;
            cnt_ff    <= nxt_cnt;
            busy_ff   <= nxt_busy;
            loaded_ff <= nxt_loaded;
        end
    end

    assign act    = act_ff;
    assign loaded = loaded_ff;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    duty_delay_a: assert property ($rose(loaded_ff) |-> $past(tick) && $past(cnt_ff) == LAST)
        else $error("Duty compare loaded before its tick count");
    duty_carry_a: assert property ($rose(loaded_ff) |-> act_ff == $past(pend_ff))
        else $error("Active duty differs from buffered value");
endmodule // hth_shadow_load
`default_nettype wire

// [rtl/hth_timer.sv]
// Eight-bit compare timer with PWM and gated carrier output, AXI4-Lite registers
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module hth_timer (
    // Clock and reset
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    // Write address channel
    input  wire logic [hth_pkg::HTH_ADDR_W-1:0]  awaddr,
    input  wire logic                            awvalid,
    output logic                                 awready,
    // Write data channel
    input  wire logic [hth_pkg::HTH_DATA_W-1:0]  wdata,
    input  wire logic [3:0]                      wstrb,
    input  wire logic                            wvalid,
    output logic                                 wready,
    // Write response channel
    output logic [1:0]                           bresp,
    output logic                                 bvalid,
    input  wire logic                            bready,
    // Read address channel
    input  wire logic [hth_pkg::HTH_ADDR_W-1:0]  araddr,
    input  wire logic                            arvalid,
    output logic                                 arready,
    // Read data channel
    output logic [hth_pkg::HTH_DATA_W-1:0]       rdata,
    output logic [1:0]                           rresp,
    output logic                                 rvalid,
    input  wire logic                            rready,
    // Timer outputs
    output logic                                 timer_out,
    output logic                                 companion_irq
);
    localparam int unsigned CW = hth_pkg::HTH_CNT_W;

    // Bus state
    logic                            aw_hold_ff, nxt_aw_hold;
    logic [hth_pkg::HTH_ADDR_W-1:0]  aw_addr_ff, nxt_aw_addr;
    logic                            w_hold_ff, nxt_w_hold;
    logic [hth_pkg::HTH_DATA_W-1:0]  w_data_ff, nxt_w_data;
    logic [3:0]                      w_strb_ff, nxt_w_strb;
    logic                            bvalid_ff, nxt_bvalid;
    logic [1:0]                      bresp_ff, nxt_bresp;
    logic                            rvalid_ff, nxt_rvalid;
    logic [1:0]                      rresp_ff, nxt_rresp;
    logic [hth_pkg::HTH_DATA_W-1:0]  rdata_ff, nxt_rdata;
    logic                            do_wr;
    logic [hth_pkg::HTH_DATA_W-1:0]  wmask;

    // Register state
    hth_pkg::hth_ctrl_t              ctrl_ff, nxt_ctrl;
    logic [CW-1:0]                   period_ff, nxt_period;
    logic [CW-1:0]                   duty_buf_ff, nxt_duty_buf;
    logic [CW-1:0]                   cmpn_ff, nxt_cmpn;
    logic                            gate_buf_ff, nxt_gate_buf;
    logic                            duty_wr;

    // Timer and companion state
    logic [CW-1:0]                   cnt_ff, nxt_cnt;
    logic                            wave_ff, nxt_wave;
    logic                            out_ff, nxt_out;
    logic [CW-1:0]                   ccnt_ff, nxt_ccnt;
    logic                            xfer_pend_ff, nxt_xfer_pend;
    logic                            gate_act_ff, nxt_gate_act;
    logic                            irq_ff, nxt_irq;
    logic                            tick, ctick, cmatch, xfer;
    logic                            duty_loaded;
    logic [CW-1:0]                   duty_act;

    // Count clock prescalers
    hth_prescale #(.SEL_W(hth_pkg::HTH_SEL_W), .DIV_W(CW)) u_pre_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .en      (ctrl_ff.run),
        .sel     (ctrl_ff.clk_sel),
        .tick    (tick)
    );

    hth_prescale #(.SEL_W(hth_pkg::HTH_SEL_W), .DIV_W(CW)) u_pre_comp (
        .aclk    (aclk),
        .aresetn (aresetn),
        .en      (ctrl_ff.cmp_run),
        .sel     (ctrl_ff.cmp_clk_sel),
        .tick    (ctick)
    );

    // Duty compare buffer, loaded flag cleared on stop so a restart waits for a rewrite
    hth_shadow_load #(.W(CW), .DELAY(hth_pkg::HTH_DUTY_LOAD_TICKS)) u_duty (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clr     (!ctrl_ff.run),
        .tick    (tick),
        .wr      (duty_wr),
        .wr_data (nxt_duty_buf),
        .act     (duty_act),
        .loaded  (duty_loaded)
    );

    // Bus handshakes
    assign awready = !aw_hold_ff && !bvalid_ff;
    assign wready  = !w_hold_ff && !bvalid_ff;
    assign arready = !rvalid_ff;
    assign bvalid  = bvalid_ff;
    assign bresp   = bresp_ff;
    assign rvalid  = rvalid_ff;
    assign rresp   = rresp_ff;
    assign rdata   = rdata_ff;
    assign do_wr   = aw_hold_ff && w_hold_ff && !bvalid_ff;
    assign wmask   = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};

    // Write path and register updates
    always_comb begin
        nxt_aw_hold  = aw_hold_ff;
        nxt_aw_addr  = aw_addr_ff;
        nxt_w_hold   = w_hold_ff;
        nxt_w_data   = w_data_ff;
        nxt_w_strb   = w_strb_ff;
        nxt_bvalid   = bvalid_ff;
        nxt_bresp    = bresp_ff;
        nxt_ctrl     = ctrl_ff;
        nxt_period   = period_ff;
        nxt_duty_buf = duty_buf_ff;
        nxt_cmpn     = cmpn_ff;
        nxt_gate_buf = gate_buf_ff;
        duty_wr      = 1'b0;
        if (awvalid && awready) begin
            nxt_aw_hold = 1'b1;
            nxt_aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            nxt_w_hold = 1'b1;
            nxt_w_data = wdata;
            nxt_w_strb = wstrb;
        end
        if (bvalid_ff && bready) begin
            nxt_bvalid = 1'b0;
        end
        if (do_wr) begin
            nxt_aw_hold = 1'b0;
            nxt_w_hold  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = hth_pkg::HTH_RESP_OKAY;
            unique case (aw_addr_ff)
                hth_pkg::HTH_OFS_CTRL: begin
                    nxt_ctrl = hth_pkg::hth_ctrl_t'((ctrl_ff & ~wmask[hth_pkg::HTH_CTRL_W-1:0])
                               | (w_data_ff[hth_pkg::HTH_CTRL_W-1:0] & wmask[hth_pkg::HTH_CTRL_W-1:0]));
                    nxt_ctrl.rsvd = 1'b0;
                end
                hth_pkg::HTH_OFS_PERIOD: begin
                    if (w_strb_ff[0]) begin
                        nxt_period = w_data_ff[CW-1:0];
                    end
                end
                hth_pkg::HTH_OFS_DUTY: begin
                    if (w_strb_ff[0]) begin
                        nxt_duty_buf = w_data_ff[CW-1:0];
                        duty_wr      = 1'b1;
                    end
                end
                hth_pkg::HTH_OFS_GATE: begin
                    if (w_strb_ff[0]) begin
                        nxt_gate_buf = w_data_ff[hth_pkg::HTH_GATE_BUF_BIT];
                    end
                end
                hth_pkg::HTH_OFS_CMPN: begin
                    if (w_strb_ff[0]) begin
                        nxt_cmpn = w_data_ff[CW-1:0];
                    end
                end
                hth_pkg::HTH_OFS_STATUS: begin
                    nxt_bresp = hth_pkg::HTH_RESP_OKAY;
                end
                default: begin
                    nxt_bresp = hth_pkg::HTH_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff  <= 1'b0;
            aw_addr_ff  <= '0;
            w_hold_ff   <= 1'b0;
            w_data_ff   <= '0;
            w_strb_ff   <= '0;
            bvalid_ff   <= 1'b0;
            bresp_ff    <= hth_pkg::HTH_RESP_OKAY;
            ctrl_ff     <= hth_pkg::HTH_CTRL_RST;
            period_ff   <= hth_pkg::HTH_PERIOD_RST;
            duty_buf_ff <= hth_pkg::HTH_DUTY_RST;
            cmpn_ff     <= hth_pkg::HTH_CMPN_RST;
            gate_buf_ff <= 1'b0;
        end else begin
            aw_hold_ff  <= nxt_aw_hold;
            aw_addr_ff  <= nxt_aw_addr;
            w_hold_ff   <= nxt_w_hold;
            w_data_ff   <= nxt_w_data;
            w_strb_ff   <= nxt_w_strb;
            bvalid_ff   <= nxt_bvalid;
            bresp_ff    <= nxt_bresp;
            ctrl_ff     <= nxt_ctrl;
            period_ff   <= nxt_period;
            duty_buf_ff <= nxt_duty_buf;
            cmpn_ff     <= nxt_cmpn;
            gate_buf_ff <= nxt_gate_buf;
        end
    end

    // Read path
    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rresp  = rresp_ff;
        nxt_rdata  = rdata_ff;
        if (rvalid_ff && rready) begin
            nxt_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = hth_pkg::HTH_RESP_OKAY;
            nxt_rdata  = '0;
            unique case (araddr)
                hth_pkg::HTH_OFS_CTRL:   nxt_rdata[hth_pkg::HTH_CTRL_W-1:0] = ctrl_ff;
                hth_pkg::HTH_OFS_PERIOD: nxt_rdata[CW-1:0] = period_ff;
                hth_pkg::HTH_OFS_DUTY:   nxt_rdata[CW-1:0] = duty_buf_ff;
                hth_pkg::HTH_OFS_CMPN:   nxt_rdata[CW-1:0] = cmpn_ff;
                hth_pkg::HTH_OFS_GATE: begin
                    nxt_rdata[hth_pkg::HTH_GATE_BUF_BIT] = gate_buf_ff;
                    nxt_rdata[hth_pkg::HTH_GATE_ACT_BIT] = gate_act_ff;
                end
                hth_pkg::HTH_OFS_STATUS: begin
                    nxt_rdata[hth_pkg::HTH_ST_CNT_LSB +: CW]  = cnt_ff;
                    nxt_rdata[hth_pkg::HTH_ST_OUT_BIT]        = out_ff;
                    nxt_rdata[hth_pkg::HTH_ST_LOAD_BIT]       = duty_loaded;
                    nxt_rdata[hth_pkg::HTH_ST_CCNT_LSB +: CW] = ccnt_ff;
                end
                default: nxt_rresp = hth_pkg::HTH_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= hth_pkg::HTH_RESP_OKAY;
            rdata_ff  <= '0;
        end else begin
            rvalid_ff <= nxt_rvalid;
            rresp_ff  <= nxt_rresp;
            rdata_ff  <= nxt_rdata;
        end
    end

    // Counter, waveform, companion counter and gate
    assign cmatch = ctick && (ccnt_ff == cmpn_ff);
    assign xfer   = xfer_pend_ff && tick;

    always_comb begin
        nxt_cnt       = cnt_ff;
        nxt_wave      = wave_ff;
        nxt_ccnt      = ccnt_ff;
        nxt_xfer_pend = xfer_pend_ff;
        nxt_gate_act  = gate_act_ff;
        if (!ctrl_ff.run || !duty_loaded) begin
            nxt_cnt  = '0;
            nxt_wave = 1'b1;
        end else if (tick) begin
            if (cnt_ff == period_ff) begin
                nxt_cnt  = '0;
                nxt_wave = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff == duty_act) begin
                    nxt_wave = 1'b0;
                end
            end
        end
        if (!ctrl_ff.cmp_run) begin
            nxt_ccnt = '0;
        end else if (ctick) begin
            nxt_ccnt = cmatch ? '0 : ccnt_ff + 1'b1;
        end
        if (xfer) begin
            nxt_gate_act  = gate_buf_ff;
            nxt_xfer_pend = 1'b0;
        end
        if (cmatch && ctrl_ff.carrier) begin
            nxt_xfer_pend = 1'b1;
        end
        if (!ctrl_ff.carrier) begin
            nxt_out = wave_ff && ctrl_ff.run && duty_loaded;
        end else if (gate_act_ff && ctrl_ff.run && duty_loaded) begin
            nxt_out = wave_ff;
        end else begin
            nxt_out = ctrl_ff.out_level;
        end
        nxt_irq = ctrl_ff.carrier ? xfer : cmatch;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff       <= '0;
            wave_ff      <= 1'b1;
            out_ff       <= 1'b0;
            ccnt_ff      <= '0;
            xfer_pend_ff <= 1'b0;
            gate_act_ff  <= 1'b0;
            irq_ff       <= 1'b0;
        end else begin
            cnt_ff       <= nxt_cnt;
            wave_ff      <= nxt_wave;
            out_ff       <= nxt_out;
            ccnt_ff      <= nxt_ccnt;
            xfer_pend_ff <= nxt_xfer_pend;
            gate_act_ff  <= nxt_gate_act;
            irq_ff       <= nxt_irq;
        end
    end

    assign timer_out     = out_ff;
    assign companion_irq = irq_ff;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_period_hit;
        ctrl_ff.run && duty_loaded && tick && cnt_ff == period_ff;
    endsequence

    period_restart_a: assert property (s_period_hit |=> cnt_ff == '0 && wave_ff)
        else $error("Counter did not restart on period match");
    duty_low_a: assert property (ctrl_ff.run && duty_loaded && tick && cnt_ff == duty_act
                                 && cnt_ff != period_ff |=> !wave_ff)
        else $error("Waveform not low after duty match");
    idle_level_a: assert property (ctrl_ff.carrier && !gate_act_ff |=> out_ff == $past(ctrl_ff.out_level))
        else $error("Carrier idle level wrong");
    carrier_pass_a: assert property (ctrl_ff.carrier && gate_act_ff && ctrl_ff.run && duty_loaded
                                     |=> out_ff == $past(wave_ff))
        else $error("Carrier not passed while gate active");
    gate_xfer_a: assert property ($changed(gate_act_ff) |-> $past(xfer) && gate_act_ff == $past(gate_buf_ff))
        else $error("Gate changed outside a transfer");
    irq_align_a: assert property (ctrl_ff.carrier && xfer |=> companion_irq && gate_act_ff == $past(gate_buf_ff))
        else $error("Carrier interrupt not aligned to gate transfer");
    irq_plain_a: assert property (!ctrl_ff.carrier && cmatch |=> companion_irq)
        else $error("Companion interrupt missing on match");
    bvalid_hold_a: assert property (bvalid_ff && !bready |=> bvalid_ff && $stable(bresp_ff))
        else $error("Write response dropped before taken");
    rvalid_hold_a: assert property (rvalid_ff && !rready |=> rvalid_ff && $stable(rdata_ff))
        else $error("Read data dropped before taken");
endmodule // hth_timer
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking testbench for the compare timer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, timer_out, companion_irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    int          mismatches, total_checks, seed, n, per, dut;

    hth_timer hth_timer_i (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .timer_out(timer_out), .companion_irq(companion_irq)
    );

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic tally_and_finish;
        if (mismatches == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic hang;
        mismatches++;
        tally_and_finish();
    endtask

    // Bus write, both channels offered together
    task automatic wrr(input logic [7:0] a, input logic [31:0] d);
        bit ha, hw, hb;
        int k;
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(negedge aclk);
            ha = awvalid && awready; hw = wvalid && wready; hb = bvalid; resp = bresp;
            @(posedge aclk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            if (hb) break;
        end
        if (k == 64) hang();
    endtask

    // Bus read
    task automatic rdr(input logic [7:0] a);
        bit ha, hr;
        int k;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(negedge aclk);
            ha = arvalid && arready; hr = rvalid; rd = rdata; resp = rresp;
            @(posedge aclk);
            if (ha) arvalid <= 1'b0;
            if (hr) break;
        end
        if (k == 64) hang();
    endtask

    // Cycles until the next rising level of a signal
    task automatic wait_rise(ref logic s, output int k);
        logic p;
        p = s;
        for (k = 0; k < 2000; k++) begin
            @(negedge aclk);
            if (s && !p) break;
            p = s;
        end
        @(posedge aclk);
        if (k == 2000) hang();
    endtask

    // Cycles a high level of the timer output lasts
    task automatic high_len(output int k);
        for (k = 0; k < 2000 && timer_out; k++) @(negedge aclk);
        @(posedge aclk);
        if (k == 2000) hang();
    endtask

    function automatic logic [31:0] ctrl(input logic [2:0] cs, input logic cr, ol,
                                         input logic [2:0] sel, input logic car, run);
        return {21'h0, cs, 1'b0, cr, ol, sel, car, run};
    endfunction

    logic [7:0]  ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    logic [31:0] rv [5] = '{32'h0, 32'hFF, 32'h0, 32'h0, 32'hFF};

    initial begin
        seed = 76023; mismatches = 0; total_checks = 0;
        aresetn <= 1'b0; awvalid <= 1'b0; wvalid <= 1'b0; bready <= 1'b0; arvalid <= 1'b0;
        rready <= 1'b0; awaddr <= 8'h00; araddr <= 8'h00; wdata <= 32'h0; wstrb <= 4'hF;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (n = 0; n < 5; n++) begin
            rdr(ra[n]);
            `CHK("reset value", rv[n], rd)
        end
        rdr(8'h20);
        `CHK("unmapped rresp", 2'h2, resp)
        wrr(8'h20, 32'h5A);
        `CHK("unmapped bresp", 2'h2, resp)
        // PWM with random compares, companion counter running in its plain mode
        per = 8 + ($random(seed) & 31);
        dut = 1 + (($random(seed) & 255) % (per - 1));
        wrr(8'h04, per);
        wrr(8'h08, dut);
        wrr(8'h00, ctrl(3'h0, 1'b1, 1'b0, 3'h2, 1'b0, 1'b1));
        rdr(8'h14);
        `CHK("duty loaded early", 1'b0, rd[9])
        repeat (40) @(posedge aclk);
        rdr(8'h14);
        `CHK("duty loaded", 1'b1, rd[9])
        wait_rise(timer_out, n);
        wait_rise(timer_out, n);
        `CHK("pwm period", (per + 1) * 4 - 1, n)
        high_len(n);
        `CHK("pwm duty", (dut + 1) * 4, n)
        // Restart without duty rewrite
        wrr(8'h00, 32'h0);
        wrr(8'h00, ctrl(3'h0, 1'b1, 1'b0, 3'h2, 1'b0, 1'b1));
        repeat (60) @(posedge aclk);
        rdr(8'h14);
        `CHK("restart load", 1'b0, rd[9])
        `CHK("restart output", 1'b0, timer_out)
        wrr(8'h08, dut);
        repeat (40) @(posedge aclk);
        rdr(8'h14);
        `CHK("reload", 1'b1, rd[9])
        // Carrier mode, level high while gated off
        wrr(8'h00, 32'h0);
        wrr(8'h04, 2 + ($random(seed) & 15));
        wrr(8'h0C, 32'h0);
        wrr(8'h10, 32'h2);
        wrr(8'h00, ctrl(3'h3, 1'b1, 1'b1, 3'h0, 1'b1, 1'b1));
        wrr(8'h08, 32'h1);
        repeat (20) @(posedge aclk);
        `CHK("idle level", 1'b1, timer_out)
        wrr(8'h0C, 32'h1);
        wait_rise(companion_irq, n);
        rdr(8'h0C);
        `CHK("gate on", 32'h3, rd)
        wait_rise(timer_out, n);
        wrr(8'h0C, 32'h0);
        wait_rise(companion_irq, n);
        rdr(8'h0C);
        `CHK("gate off", 32'h0, rd)
        `CHK("gated level", 1'b1, timer_out)
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
